/* core/bmc_top.sv */
// Button menu controller: gestures, menu, digit editing, Wishbone registers
//
// Our own choices: the placing of the registers and the Wishbone register port.
module bmc_top
  import bmc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned ARM_T = ARM_TICKS,
  parameter int unsigned CAL_T = CAL_TICKS,
  parameter int unsigned MENU_T = MENU_TICKS,
  parameter int unsigned IDLE_T = IDLE_TICKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic back_key,
  input wire logic pick_key,
  input wire logic ok_key,
  input wire logic [31:0] pressure,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [31:0] zero_offset,
  output logic [31:0] range_lower,
  output logic [31:0] range_upper,
  output logic [31:0] damping,
  output logic [3:0] range_unit,
  output logic side_swap,
  output logic check_mark,
  output logic menu_active,
  output logic factory_reset
);
  logic rs1_q, rs2_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire logic rst_n = rs2_q;

  bmc_key_if kif();
  bmc_keys #(.TICK_DIV(TICK_DIV)) u_keys (
    .clk(clk),
    .rst_n(rst_n),
    .keys_raw({ok_key, pick_key, back_key}),
    .kif(kif)
  );
  wire logic back_l = kif.level[0];
  wire logic pick_l = kif.level[1];
  wire logic ok_l = kif.level[2];
  wire logic any_l = |kif.level;
  wire logic back_p = kif.press[0];
  wire logic pick_p = kif.press[1];
  wire logic ok_p = kif.press[2];

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] bcd_val(input logic [23:0] d);
    logic [31:0] v;
    v = 32'h0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      v = v * 32'd10 + {28'h0, d[i*4 +: 4]};
    end
    return d[20] ? -v : v;
  endfunction

  bmc_state_e st_q, st_d;
  logic [22:0] tmr_q, tmr_d, idle_q, idle_d;
  logic [7:0] settle_q, settle_d;
  logic [2:0] item_q, item_d, place_q, place_d, dp_q, dp_d;
  logic [23:0] dig_q, dig_d;
  logic [3:0] unit_sel_q, unit_sel_d;
  logic [31:0] ctrl_q, ctrl_d, zero_q, zero_d, low_q, low_d, up_q, up_d, damp_q, damp_d;
  logic [3:0] unit_q, unit_d;
  logic swap_q, swap_d, chk_q, chk_d, fr_q, fr_d, ack_q, ack_d, menu_q, menu_d;
  logic [31:0] dat_q, dat_d;
  logic [1:0] gest_q, gest_d;
  wire logic wp = ctrl_q[CTRL_WP_BIT];
  wire logic in_cfg = (st_q == BMC_MENU) || (st_q == BMC_UNIT) || (st_q == BMC_EDIT);
  wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_q;

  always_comb begin
    st_d = st_q;
    tmr_d = (kif.tick && tmr_q != 23'h7FFFFF) ? tmr_q + 23'h1 : tmr_q;
    idle_d = kif.tick ? idle_q + 23'h1 : idle_q;
    settle_d = settle_q;
    item_d = item_q;
    place_d = place_q;
    dp_d = dp_q;
    dig_d = dig_q;
    unit_sel_d = unit_sel_q;
    ctrl_d = ctrl_q;
    zero_d = zero_q;
    low_d = low_q;
    up_d = up_q;
    damp_d = damp_q;
    unit_d = unit_q;
    swap_d = swap_q;
    chk_d = chk_q;
    fr_d = 1'b0;
    gest_d = gest_q;
    if (|kif.press) begin
      idle_d = 23'h0;
    end
    case (st_q)
      BMC_MEAS: begin
        tmr_d = 23'h0;
        if (back_l && pick_l && !ok_l) begin
          st_d = BMC_FIRST;
        end else if (ok_l && !back_l && !pick_l) begin
          st_d = BMC_MHOLD;
        end
      end
      BMC_FIRST: begin
        if (!back_l && !pick_l) begin
          st_d = (tmr_q >= 23'(ARM_T)) ? BMC_ARMED : BMC_MEAS;
          tmr_d = 23'h0;
        end else if (!back_l || !pick_l || ok_l) begin
          st_d = BMC_WAITREL;
        end
      end
      BMC_WAITREL: begin
        if (!any_l) begin
          st_d = BMC_MEAS;
        end
      end
      BMC_ARMED: begin
        if (back_l || pick_l) begin
          st_d = BMC_SECOND;
          tmr_d = 23'h0;
          settle_d = 8'h00;
        end else if (tmr_q >= 23'(IDLE_T)) begin
          st_d = BMC_MEAS;
        end
      end
      BMC_SECOND: begin
        if (kif.tick && settle_q != 8'hFF) begin
          settle_d = settle_q + 8'h01;
        end
        if (!back_l && !pick_l || ok_l) begin
          st_d = BMC_WAITREL;
        end else if (settle_q < 8'(SETTLE_TICKS) && gest_q != {back_l, pick_l}) begin
          gest_d = {back_l, pick_l};
          tmr_d = 23'h0;
        end else if (gest_q != {back_l, pick_l}) begin
          st_d = BMC_WAITREL;
        end else if (tmr_q >= 23'(CAL_T)) begin
          st_d = BMC_WAITREL;
          case ({back_l, pick_l})
            2'b11: zero_d = pressure;
            2'b01: begin
              low_d = pressure;
              up_d = pressure + (up_q - low_q);
            end
            2'b10: up_d = pressure;
            default: ;
          endcase
        end
      end
      BMC_MHOLD: begin
        if (!ok_l) begin
          st_d = (tmr_q >= 23'(MENU_T)) ? BMC_MENU : BMC_MEAS;
          item_d = ITEM_UNIT;
          idle_d = 23'h0;
          chk_d = 1'b0;
        end else if (back_l || pick_l) begin
          st_d = BMC_WAITREL;
        end
      end
      BMC_MENU: begin
        if (back_p) begin
          item_d = ITEM_UNIT;
          chk_d = 1'b0;
        end else if (pick_p) begin
          item_d = (item_q == ITEM_COUNT - 3'h1) ? 3'h0 : item_q + 3'h1;
          chk_d = 1'b0;
        end else if (ok_p) begin
          chk_d = 1'b0;
          place_d = 3'h0;
          case (item_q)
            ITEM_UNIT: begin
              st_d = BMC_UNIT;
              unit_sel_d = unit_q;
            end
            ITEM_SWAP: begin
              if (!wp) begin
                swap_d = !swap_q;
                chk_d = 1'b1;
              end
            end
            default: begin
              st_d = BMC_EDIT;
              dig_d = 24'h0;
              dp_d = 3'h0;
            end
          endcase
        end
      end
      BMC_UNIT: begin
        if (pick_p) begin
          unit_sel_d = (unit_sel_q == UNIT_COUNT - 4'h1) ? 4'h0 : unit_sel_q + 4'h1;
        end else if (ok_p) begin
          st_d = BMC_MENU;
          if (!wp) begin
            unit_d = unit_sel_q;
            chk_d = 1'b1;
          end
        end else if (back_p) begin
          st_d = BMC_MENU;
        end
      end
      BMC_EDIT: begin
        if (back_p) begin
          place_d = (place_q == PLACE_SIGN) ? 3'h0 : place_q + 3'h1;
        end else if (pick_p) begin
          if (place_q == PLACE_SIGN) begin
            dig_d[20] = !dig_q[20];
          end else if (place_q == PLACE_DP) begin
            dp_d = (dp_q == 3'(DIGITS - 1)) ? 3'h0 : dp_q + 3'h1;
          end else begin
            dig_d[place_q*4 +: 4] = (dig_q[place_q*4 +: 4] == 4'h9) ? 4'h0 : dig_q[place_q*4 +: 4] + 4'h1;
          end
        end else if (ok_p) begin
          st_d = BMC_MENU;
          if (!wp) begin
            chk_d = 1'b1;
            if (item_q == ITEM_DAMP && dig_q == FACTORY_CODE && dp_q == FACTORY_DP) begin
              fr_d = 1'b1;
              low_d = LOWER_RST;
              up_d = UPPER_RST;
              damp_d = DAMP_RST;
              zero_d = 32'h0;
              unit_d = UNIT_RST;
              swap_d = 1'b0;
            end else if (item_q == ITEM_DAMP) begin
              damp_d = bcd_val(dig_q);
            end else if (item_q == ITEM_LOWER) begin
              low_d = bcd_val(dig_q);
            end else begin
              up_d = bcd_val(dig_q);
            end
          end
        end
      end
      default: st_d = BMC_MEAS;
    endcase
    if (in_cfg && idle_q >= 23'(IDLE_T)) begin
      st_d = BMC_MEAS;
      chk_d = 1'b0;
    end
    menu_d = (st_d == BMC_MENU) || (st_d == BMC_UNIT) || (st_d == BMC_EDIT);
    ack_d = wb_req;
    dat_d = dat_q;
    if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: ctrl_d = wmask(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
        ADR_DAMP: damp_d = wmask(damp_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end else if (wb_req) begin
      case (wb_adr_i)
        ADR_CTRL: dat_d = ctrl_q;
        ADR_STATUS: dat_d = {16'h0, unit_q, 3'h0, swap_q, 3'h0, chk_q, st_q};
        ADR_PRESS: dat_d = pressure;
        ADR_LOWER: dat_d = low_q;
        ADR_UPPER: dat_d = up_q;
        ADR_ZERO: dat_d = zero_q;
        ADR_DAMP: dat_d = damp_q;
        ADR_MENU: dat_d = {25'h0, item_q, unit_sel_q};
        ADR_EDIT: dat_d = {2'h0, dp_q, 3'h0, dig_q};
        default: dat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= BMC_MEAS;
      tmr_q <= 23'h0;
      idle_q <= 23'h0;
      settle_q <= 8'h00;
      item_q <= 3'h0;
      place_q <= 3'h0;
      dp_q <= 3'h0;
      dig_q <= 24'h0;
      unit_sel_q <= 4'h0;
      ctrl_q <= CTRL_RST;
      zero_q <= 32'h0;
      low_q <= LOWER_RST;
      up_q <= UPPER_RST;
      damp_q <= DAMP_RST;
      unit_q <= UNIT_RST;
      swap_q <= 1'b0;
      chk_q <= 1'b0;
      fr_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      gest_q <= 2'h0;
      menu_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      idle_q <= idle_d;
      settle_q <= settle_d;
      item_q <= item_d;
      place_q <= place_d;
      dp_q <= dp_d;
      dig_q <= dig_d;
      unit_sel_q <= unit_sel_d;
      ctrl_q <= ctrl_d;
      zero_q <= zero_d;
      low_q <= low_d;
      up_q <= up_d;
      damp_q <= damp_d;
      unit_q <= unit_d;
      swap_q <= swap_d;
      chk_q <= chk_d;
      fr_q <= fr_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      gest_q <= gest_d;
      menu_q <= menu_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign zero_offset = zero_q;
  assign range_lower = low_q;
  assign range_upper = up_q;
  assign damping = damp_q;
  assign range_unit = unit_q;
  assign side_swap = swap_q;
  assign check_mark = chk_q;
  assign menu_active = menu_q;
  assign factory_reset = fr_q;
endmodule

/* common/bmc_pkg.sv */
// Package: register map, timing and encodings of the button menu controller
package bmc_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned DEB_MS = 20;
  localparam int unsigned DEB_TICKS = DEB_MS * 1000 / TICK_US;
  localparam int unsigned ARM_HOLD_S = 5;
  localparam int unsigned ARM_TICKS = ARM_HOLD_S * 1_000_000 / TICK_US + 1;
  localparam int unsigned CAL_HOLD_S = 2;
  localparam int unsigned CAL_TICKS = CAL_HOLD_S * 1_000_000 / TICK_US;
  localparam int unsigned MENU_HOLD_S = 5;
  localparam int unsigned MENU_TICKS = MENU_HOLD_S * 1_000_000 / TICK_US;
  localparam int unsigned IDLE_S = 15;
  localparam int unsigned IDLE_TICKS = IDLE_S * 1_000_000 / TICK_US;
  localparam int unsigned SETTLE_TICKS = 200;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_PRESS = 8'h08;
  localparam logic [7:0] ADR_LOWER = 8'h0C;
  localparam logic [7:0] ADR_UPPER = 8'h10;
  localparam logic [7:0] ADR_ZERO = 8'h14;
  localparam logic [7:0] ADR_DAMP = 8'h18;
  localparam logic [7:0] ADR_MENU = 8'h1C;
  localparam logic [7:0] ADR_EDIT = 8'h20;

  localparam int unsigned CTRL_WP_BIT = 0;
  localparam int unsigned CTRL_LCD_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] LOWER_RST = 32'h0000_0000;
  localparam logic [31:0] UPPER_RST = 32'h0000_1388;
  localparam logic [31:0] DAMP_RST = 32'h0000_0000;
  localparam logic [3:0] UNIT_RST = 4'h0;
  localparam logic [3:0] UNIT_COUNT = 4'h6;

  localparam int unsigned DIGITS = 5;
  localparam logic [2:0] PLACE_DP = 3'h5;
  localparam logic [2:0] PLACE_SIGN = 3'h6;
  localparam logic [23:0] FACTORY_CODE = 24'h088888;
  localparam logic [2:0] FACTORY_DP = 3'h3;

  localparam logic [2:0] ITEM_UNIT = 3'h0;
  localparam logic [2:0] ITEM_LOWER = 3'h1;
  localparam logic [2:0] ITEM_UPPER = 3'h2;
  localparam logic [2:0] ITEM_DAMP = 3'h3;
  localparam logic [2:0] ITEM_SWAP = 3'h4;
  localparam logic [2:0] ITEM_COUNT = 3'h5;

  typedef enum logic [3:0] {
    BMC_MEAS, BMC_FIRST, BMC_WAITREL, BMC_ARMED, BMC_SECOND,
    BMC_MHOLD, BMC_MENU, BMC_UNIT, BMC_EDIT
  } bmc_state_e;
endpackage

/* common/bmc_key_if.sv */
// Interface: debounced key levels and press pulses
interface bmc_key_if;
  logic [2:0] level;
  logic [2:0] press;
  logic tick;
  modport src (output level, output press, output tick);
  modport dst (input level, input press, input tick);
endinterface

/* core/bmc_keys.sv */
// Tick divider and debouncers for the three keys
module bmc_keys
  import bmc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] keys_raw,
  bmc_key_if.src kif
);
  logic [17:0] div_q, div_d;
  logic tick_q, tick_d;
  logic [4:0] cnt_q [3], cnt_d [3];
  logic [2:0] lvl_q, lvl_d, prs_q, prs_d;

  assign kif.level = lvl_q;
  assign kif.press = prs_q;
  assign kif.tick = tick_q;

  always_comb begin
    tick_d = 1'b0;
    div_d = div_q + 18'h00001;
    if (div_q == 18'(TICK_DIV - 1)) begin
      div_d = 18'h00000;
      tick_d = 1'b1;
    end
    lvl_d = lvl_q;
    prs_d = 3'h0;
    for (int i = 0; i < 3; i++) begin
      cnt_d[i] = cnt_q[i];
      if (keys_raw[i] == lvl_q[i]) begin
        cnt_d[i] = 5'h00;
      end else if (tick_q) begin
        cnt_d[i] = cnt_q[i] + 5'h01;
        if (cnt_q[i] == 5'(DEB_TICKS - 1)) begin
          cnt_d[i] = 5'h00;
          lvl_d[i] = keys_raw[i];
          prs_d[i] = keys_raw[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 18'h00000;
      tick_q <= 1'b0;
      lvl_q <= 3'h0;
      prs_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= 5'h00;
      end
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      lvl_q <= lvl_d;
      prs_q <= prs_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

/* sim/bmc_checker.sv */
// Port-level assertions for the button menu controller
module bmc_checker
  import bmc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned IDLE_T = IDLE_TICKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic back_key,
  input wire logic pick_key,
  input wire logic ok_key,
  input wire logic [31:0] pressure,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] zero_offset,
  input wire logic [31:0] range_lower,
  input wire logic [31:0] range_upper,
  input wire logic [31:0] damping,
  input wire logic [3:0] range_unit,
  input wire logic side_swap,
  input wire logic check_mark,
  input wire logic menu_active,
  input wire logic factory_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slack covers debounce lag and tick phase
  localparam int unsigned IDLE_MAX = (IDLE_T + DEB_TICKS + 2) * TICK_DIV;
  int unsigned idle_q;
  int unsigned idle_d;
  always_comb begin
    idle_d = 0;
    if (menu_active && !(back_key || pick_key || ok_key)) begin
      idle_d = idle_q + 1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= 0;
    end else begin
      idle_q <= idle_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  zero_alone_a: assert property (($changed(zero_offset) && !factory_reset) |->
    ($stable(range_lower) && $stable(range_upper))) else $error("rezero moved the range");
  span_kept_a: assert property (($changed(range_lower) && !factory_reset && !$past(menu_active)) |->
    (range_upper - range_lower == $past(range_upper) - $past(range_lower))) else $error("span changed");
  upper_alone_a: assert property (($changed(range_upper) && $stable(range_lower)) |->
    $stable(zero_offset)) else $error("upper set moved zero");
  fr_pulse_a: assert property (factory_reset |=> !factory_reset)
    else $error("factory pulse too long");
  fr_values_a: assert property (factory_reset |-> (range_upper == UPPER_RST && range_lower == LOWER_RST
    && damping == DAMP_RST && range_unit == UNIT_RST)) else $error("defaults not restored");
  unit_menu_a: assert property (($changed(range_unit) && !factory_reset) |->
    ($past(menu_active) && range_unit < UNIT_COUNT)) else $error("unit changed outside menu");
  mark_menu_a: assert property ($rose(check_mark) |-> menu_active)
    else $error("check mark outside menu");
  idle_exit_a: assert property (idle_q <= IDLE_MAX)
    else $error("menu stayed open while idle");
  cover property (factory_reset);
  cover property ($rose(menu_active));
  cover property ($changed(zero_offset));
endmodule

bind bmc_top bmc_checker #(.TICK_DIV(TICK_DIV), .IDLE_T(IDLE_T)) chk_u (.clk, .rstn, .back_key, .pick_key,
  .ok_key, .pressure, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .zero_offset, .range_lower, .range_upper, .damping, .range_unit, .side_swap, .check_mark, .menu_active,
  .factory_reset);

/* sim/bmc_operator.sv */
// Operator model: presses the three panel keys and sets the pressure
module bmc_operator
  import bmc_pkg::*;
#(
  // Bench tick divider, kept equal to the one given to the design
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic clk,
  output logic back_key,
  output logic pick_key,
  output logic ok_key,
  output logic [31:0] pressure
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ok_key, pick_key, back_key} = 3'h0;
    pressure = 32'h0;
  end
  // One assignment moves all keys, so two-key releases are even
  task automatic hold(input logic [2:0] k, input int unsigned t);
    @(posedge clk);
    {ok_key, pick_key, back_key} <= k;
    repeat (t * TICK_DIV) @(posedge clk);
    {ok_key, pick_key, back_key} <= 3'h0;
    repeat (40 * TICK_DIV) @(posedge clk);
  endtask
  task automatic apply(input logic [31:0] p);
    @(posedge clk);
    pressure <= p;
  endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench: registers, gestures, menu, editing, idle exit
module testbench
  import bmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TD = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, zero_offset, range_lower, range_upper, damping, pressure;
  logic [3:0] range_unit;
  logic wb_ack_o, side_swap, check_mark, menu_active, factory_reset, back_key, pick_key, ok_key;
  logic fr_seen = 1'b0;
  int fails = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (factory_reset === 1'b1) fr_seen <= 1'b1;
  bmc_operator op_u (.clk, .back_key, .pick_key, .ok_key, .pressure);
  bmc_top #(.TICK_DIV(TD), .ARM_T(50), .CAL_T(8), .MENU_T(20), .IDLE_T(600)) dut_u (.clk, .rstn,
    .back_key, .pick_key, .ok_key, .pressure, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .zero_offset, .range_lower, .range_upper, .damping, .range_unit,
    .side_swap, .check_mark, .menu_active, .factory_reset);
  task automatic conclude();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, s};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) fails++;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic tap(input logic [2:0] k, input int n);
    repeat (n) op_u.hold(k, 30);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, ADR_CTRL, 32'h0, q);
    chk(q, CTRL_RST);
    wb(1'b0, ADR_UPPER, 32'h0, q);
    chk(q, UPPER_RST);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'hFC, 32'h0, q);
    chk(q, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_gest();
    op_u.apply(32'h0000_0123);
    op_u.hold(3'h3, 70);
    op_u.hold(3'h3, 300);
    chk(zero_offset, 32'h0000_0123);
    chk(range_lower, LOWER_RST);
    // Short first stage never arms; a lone pick in measurement means nothing
    op_u.apply(32'h0000_0100);
    op_u.hold(3'h3, 30);
    op_u.hold(3'h2, 300);
    chk(range_lower, LOWER_RST);
    op_u.hold(3'h3, 70);
    op_u.hold(3'h2, 300);
    chk(range_lower, 32'h0000_0100);
    chk(range_upper, 32'h0000_1488);
    op_u.apply(32'h0000_1000);
    op_u.hold(3'h3, 70);
    op_u.hold(3'h1, 300);
    chk(range_upper, 32'h0000_1000);
    chk(range_lower, 32'h0000_0100);
    $display("test gestures done");
  endtask
  task automatic t_menu();
    logic [31:0] q;
    op_u.hold(3'h4, 70);
    chk(32'(menu_active), 32'h1);
    tap(3'h2, 2);
    tap(3'h1, 1);
    wb(1'b0, ADR_MENU, 32'h0, q);
    chk(32'(q[6:4]), 32'(ITEM_UNIT));
    tap(3'h4, 1);
    tap(3'h2, 1);
    tap(3'h4, 1);
    chk(32'(range_unit), 32'h1);
    chk(32'(check_mark), 32'h1);
    tap(3'h2, 4);
    wb(1'b1, ADR_CTRL, 32'h3, q);
    tap(3'h4, 1);
    chk(32'(side_swap), 32'h0);
    chk(32'(check_mark), 32'h0);
    wb(1'b1, ADR_CTRL, 32'h2, q);
    tap(3'h4, 1);
    chk(32'(side_swap), 32'h1);
    // Unit 1, swapped, check mark, state menu
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(q, 32'h0000_1116);
    $display("test menu done");
  endtask
  task automatic t_edit();
    logic [31:0] q;
    int i;
    // Only the low byte lane is enabled
    wb(1'b1, ADR_DAMP, 32'hAAAA_AA55, q, 4'h1);
    wb(1'b0, ADR_DAMP, 32'h0, q);
    chk(q, 32'h0000_0055);
    tap(3'h1, 1);
    tap(3'h2, 3);
    tap(3'h4, 1);
    for (i = 0; i < DIGITS; i++) begin
      tap(3'h2, 8);
      tap(3'h1, 1);
    end
    // Point starts at zero on entering the edit, so step until it reads three
    wb(1'b0, ADR_EDIT, 32'h0, q);
    for (i = 0; i < 8 && q[29:27] !== FACTORY_DP; i++) begin
      tap(3'h2, 1);
      wb(1'b0, ADR_EDIT, 32'h0, q);
    end
    chk(32'(q[23:0]), 32'(FACTORY_CODE));
    chk(32'(q[29:27]), 32'(FACTORY_DP));
    tap(3'h4, 1);
    chk(32'(fr_seen), 32'h1);
    chk(damping, DAMP_RST);
    chk(range_upper, UPPER_RST);
    chk(32'(menu_active), 32'h1);
    // Lower limit edited to minus two through the sign place
    tap(3'h1, 1);
    tap(3'h2, 1);
    tap(3'h4, 1);
    tap(3'h2, 2);
    tap(3'h1, 6);
    tap(3'h2, 1);
    tap(3'h4, 1);
    chk(range_lower, 32'hFFFF_FFFE);
    chk(range_upper, UPPER_RST);
    $display("test edit done");
  endtask
  task automatic t_idle();
    repeat (640 * TD) @(posedge clk);
    chk(32'(menu_active), 32'h0);
    $display("test idle done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_gest();
    t_menu();
    t_edit();
    t_idle();
    conclude();
  end
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule
